//--- hca_pkg.sv
// package for the hub configuration store and autoload sequencer
// assumes a byte-wide eeprom read port (address out, data back with a valid strobe)
package hca_pkg;
	// avalon word offsets of the register file
	localparam logic [3:0] OFF_PORTNUM   = 4'h0; // port numbering byte
	localparam logic [3:0] OFF_UPBOOST   = 4'h1; // upstream drive boost
	localparam logic [3:0] OFF_DNBOOST_H = 4'h2; // downstream port 5 boost
	localparam logic [3:0] OFF_DNBOOST_L = 4'h3; // downstream ports 4..2 boost
	localparam logic [3:0] OFF_STATCMD   = 4'h4; // status / command
	localparam logic [3:0] OFF_LOADSTAT  = 4'h5; // loader status, read only
	localparam logic [3:0] OFF_RELOAD    = 4'h6; // write 1: eeprom reload command
	localparam logic [3:0] OFF_MAC_LO    = 4'h7; // loaded mac, low 32 bits
	localparam logic [3:0] OFF_MAC_HI    = 4'h8; // loaded mac, high 16 bits
	localparam logic [3:0] OFF_ETHCFG    = 4'h9; // fs poll, hs poll, flags, max power
	localparam logic [3:0] OFF_PORTMAP   = 4'ha; // effective logical port numbers
	// field positions
	localparam int PORTSEL_BIT = 3; // port_renumber_select
	localparam int SOFTWARE_RESET_CMD_BIT    = 1; // software_reset_cmd
	localparam int ATTACH_BIT  = 0; // attach and write protect
	// reset values
	localparam logic [7:0] RST_PORTNUM  = 8'h00;
	localparam logic [7:0] RST_UPBOOST  = 8'h00;
	localparam logic [7:0] RST_DNBOOST  = 8'h00;
	localparam logic [7:0] RST_STATCMD  = 8'h01;
	localparam logic [47:0] DEF_MAC     = 48'hffff_ffff_ffff;
	localparam logic [7:0] DEF_FS_POLL  = 8'h01;
	localparam logic [7:0] DEF_HS_POLL  = 8'h04;
	localparam logic [7:0] DEF_CFGFLAGS = 8'h05;
	localparam logic [7:0] DEF_MAXPOWER = 8'h01;
	// eeprom layout
	localparam logic [7:0] SIGNATURE    = 8'ha5;
	localparam logic [7:0] EE_SIG       = 8'h00;
	localparam logic [7:0] EE_MAC0      = 8'h01; // six bytes 01h..06h
	localparam logic [7:0] EE_FS_POLL   = 8'h07;
	localparam logic [7:0] EE_HS_POLL   = 8'h08;
	localparam logic [7:0] EE_CFGFLAGS  = 8'h09;
	localparam logic [7:0] EE_PORTNUM   = 8'h28;
	localparam logic [7:0] EE_DIS_SELF  = 8'h2a;
	localparam logic [7:0] EE_DIS_BUS   = 8'h2b;
	localparam logic [7:0] EE_UPBOOST   = 8'h2c;
	localparam logic [7:0] EE_DNBOOST_H = 8'h2d;
	localparam logic [7:0] EE_DNBOOST_L = 8'h2e;
	localparam logic [7:0] EE_MAXPOWER  = 8'h33;
	localparam logic [7:0] EE_REMAP12   = 8'h36;
	localparam logic [7:0] EE_REMAP34   = 8'h37;
	localparam logic [7:0] EE_REMAP5    = 8'h38;
	// load scopes
	typedef enum logic [1:0] {
		HCA_SCOPE_FULL = 2'h0, // hub and ethernet
		HCA_SCOPE_MAC  = 2'h1, // mac only
		HCA_SCOPE_ETH  = 2'h2  // ethernet only
	} hca_scope_e;
	// loader states, one-hot
	typedef enum logic [4:0] {
		HCA_IDLE = 5'h01,
		HCA_REQ  = 5'h02,
		HCA_WAIT = 5'h04,
		HCA_NEXT = 5'h08,
		HCA_DONE = 5'h10
	} hca_state_e;
endpackage

//--- hca_config_autoload.sv
// hub configuration store with reset-time eeprom autoload and avalon-mm slave
// assumes a simple eeprom reader outside: ee_rd_req/ee_addr, answered by ee_rd_valid/ee_rd_data
// also assumes the reader answers every request exactly once
// and that self_powered is a strap already in this clock's domain
`timescale 1ns/1ns

module hca_config_autoload (
	input  wire logic        clock,
	input  wire logic        rst,                   // power-on reset, synchronous
	input  wire logic        external_reset_pin_n,  // asynchronous pin
	input  wire logic        usb_bus_reset,         // pulse from hub core
	input  wire logic        self_powered,          // strap level, same domain
	// avalon-mm slave
	input  wire logic [5:0]  avs_address,           // byte address
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [1:0]  avs_response,
	// eeprom read port
	output logic             ee_rd_req,
	output logic      [7:0]  ee_addr,
	input  wire logic        ee_rd_valid,
	input  wire logic [7:0]  ee_rd_data,
	// outputs to hub and ethernet
	output logic             usb_attach,
	output logic      [1:0]  upstream_drive_level,
	output logic      [1:0]  second_port_drive_level,
	output logic      [1:0]  third_port_drive_level,
	output logic      [1:0]  fourth_port_drive_level,
	output logic      [1:0]  fifth_port_drive_level,
	output logic      [14:0] port_logical_num,      // 3 bits per physical port 1..5
	output logic      [47:0] mac_address,
	output logic             load_busy
);

	////////////////////////////////////////////////////////////////////////////
	// state
	// every field of the block lives in one packed struct:
	// synchroniser, hub bytes, ethernet bytes, loader and bus answer
	// so one flop bank carries the whole synchronous reset
	typedef struct packed {
		logic [2:0]          pin_sync;   // pin synchroniser
		logic                pin_level;  // agreed pin level
		logic [7:0]          portnum;
		logic [7:0]          upboost;
		logic [7:0]          dnboost_h;
		logic [7:0]          dnboost_l;
		logic                attach;
		logic                attach_wr;  // attach already written once
		logic [7:0]          dis_self;
		logic [7:0]          dis_bus;
		logic [7:0]          remap12;
		logic [7:0]          remap34;
		logic [7:0]          remap5;
		logic [47:0]         mac;
		logic [7:0]          fs_poll;
		logic [7:0]          hs_poll;
		logic [7:0]          cfgflags;
		logic [7:0]          maxpower;
		hca_pkg::hca_state_e st;
		hca_pkg::hca_scope_e scope;
		logic [7:0]          addr;
		logic                sig_ok;
		logic                req;
		logic                ack;        // bus answer strobe
		logic [31:0]         rdata;
	} hca_state_s;

	hca_state_s r;       // registered state
	hca_state_s next_r;  // next value

	// combinational helpers, given a value on every pass
	logic       pin_fall;      // hardware reset pin asserted
	logic       wr_go;         // write accepted this cycle
	logic [3:0] widx;          // word index
	logic [7:0] wb;            // byte lane 0 of write data
	logic [7:0] dis_set;       // active disable set
	logic [2:0] cnt;           // running logical number

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		next_r = r;
		// pin passes three flops; a change counts when stages two and three agree
		// stage one may be metastable and is read only by stage two
		next_r.pin_sync = {r.pin_sync[1:0], external_reset_pin_n};
		if (r.pin_sync[2] == r.pin_sync[1]) begin
			next_r.pin_level = r.pin_sync[2];
		end
		// a fall counts once; a glitch under two cycles is lost
		pin_fall = r.pin_level && (r.pin_sync[2] == r.pin_sync[1]) && !r.pin_sync[2];
		// word index and byte lane 0; upper lanes carry nothing
		widx = avs_address[5:2];
		wb   = avs_writedata[7:0];
		// exactly one wait state: the first cycle raises ack
		// a write lands on the edge that sees waitrequest low,
		// so an access dropped in its wait state changes nothing
		wr_go = avs_write && r.ack;
		// ack clears itself, so a held request starts afresh
		next_r.ack = (avs_read || avs_write) && !r.ack;
		// the eeprom request is a one-cycle pulse
		next_r.req = 1'b0;

		// bus write decode; config range locked while attached
		if (wr_go && avs_byteenable[0]) begin
			case (widx)
				// only the renumber select bit is kept
				hca_pkg::OFF_PORTNUM: begin
					if (!r.attach) next_r.portnum = wb & 8'h08;
				end
				// reserved bits are dropped, so they read zero
				hca_pkg::OFF_UPBOOST: begin
					if (!r.attach) next_r.upboost = wb & 8'h03;
				end
				// port 5 field only
				hca_pkg::OFF_DNBOOST_H: begin
					if (!r.attach) next_r.dnboost_h = wb & 8'h03;
				end
				// ports 4, 3 and 2; bits 1:0 stay zero
				hca_pkg::OFF_DNBOOST_L: begin
					if (!r.attach) next_r.dnboost_l = wb & 8'hfc;
				end
				hca_pkg::OFF_STATCMD: begin
					// attach may be written only once
					// the soft reset bit is handled further down
					if (!r.attach_wr) begin
						next_r.attach    = wb[hca_pkg::ATTACH_BIT];
						next_r.attach_wr = 1'b1;
					end
				end
				// a reload while a load runs is ignored
				hca_pkg::OFF_RELOAD: begin
					if (wb[0] && r.st == hca_pkg::HCA_IDLE) begin
						next_r.st    = hca_pkg::HCA_REQ;
						next_r.scope = hca_pkg::HCA_SCOPE_ETH;
						next_r.addr  = hca_pkg::EE_SIG;
					end
				end
				default: begin
				end
			endcase
		end

		// read mux; data is registered, so it shows the state
		// of the cycle before the answer
		// soft reset bit reads zero; unmapped words read zero
		case (widx)
			hca_pkg::OFF_PORTNUM:   next_r.rdata = {24'h0, r.portnum};
			hca_pkg::OFF_UPBOOST:   next_r.rdata = {24'h0, r.upboost};
			hca_pkg::OFF_DNBOOST_H: next_r.rdata = {24'h0, r.dnboost_h};
			hca_pkg::OFF_DNBOOST_L: next_r.rdata = {24'h0, r.dnboost_l};
			hca_pkg::OFF_STATCMD:   next_r.rdata = {30'h0, 1'b0, r.attach};
			hca_pkg::OFF_LOADSTAT:  next_r.rdata = {30'h0, r.sig_ok, r.st != hca_pkg::HCA_IDLE};
			hca_pkg::OFF_MAC_LO:    next_r.rdata = r.mac[31:0];
			hca_pkg::OFF_MAC_HI:    next_r.rdata = {16'h0, r.mac[47:32]};
			hca_pkg::OFF_ETHCFG:    next_r.rdata = {r.maxpower, r.cfgflags, r.hs_poll, r.fs_poll};
			hca_pkg::OFF_PORTMAP:   next_r.rdata = {17'h0, port_logical_num};
			default:                next_r.rdata = 32'h0;
		endcase

		// loader sequencer
		// idle: wait for a reset, usb reset or reload
		// req: one request pulse, address already standing
		// wait: hold the address until the reader answers
		// next: pick the following byte by scope, or finish
		// done: one cycle so busy falls cleanly
		// no timeout: a silent reader leaves the hub detached,
		// which is safer than attaching on half a load
		case (r.st)
			hca_pkg::HCA_IDLE: begin
			end
			hca_pkg::HCA_REQ: begin
				next_r.req = 1'b1;
				next_r.st  = hca_pkg::HCA_WAIT;
			end
			hca_pkg::HCA_WAIT: begin
				if (ee_rd_valid) begin
					next_r.st = hca_pkg::HCA_NEXT;
					// the signature decides whether more is fetched
					if (r.addr == hca_pkg::EE_SIG) begin
						next_r.sig_ok = (ee_rd_data == hca_pkg::SIGNATURE);
						if (ee_rd_data != hca_pkg::SIGNATURE) begin
							next_r.st = hca_pkg::HCA_DONE;
						end
					end else if (r.addr >= hca_pkg::EE_MAC0 && r.addr < hca_pkg::EE_FS_POLL) begin
						next_r.mac = {r.mac[39:0], ee_rd_data}; // first byte ends most significant
					end else begin
						// hub bytes come only in a full load
						case (r.addr)
							hca_pkg::EE_FS_POLL:   next_r.fs_poll   = ee_rd_data;
							hca_pkg::EE_HS_POLL:   next_r.hs_poll   = ee_rd_data;
							hca_pkg::EE_CFGFLAGS:  next_r.cfgflags  = ee_rd_data;
							hca_pkg::EE_MAXPOWER:  next_r.maxpower  = ee_rd_data;
							hca_pkg::EE_PORTNUM:   next_r.portnum   = ee_rd_data & 8'h08;
							hca_pkg::EE_DIS_SELF:  next_r.dis_self  = ee_rd_data;
							hca_pkg::EE_DIS_BUS:   next_r.dis_bus   = ee_rd_data;
							hca_pkg::EE_UPBOOST:   next_r.upboost   = ee_rd_data & 8'h03;
							hca_pkg::EE_DNBOOST_H: next_r.dnboost_h = ee_rd_data & 8'h03;
							hca_pkg::EE_DNBOOST_L: next_r.dnboost_l = ee_rd_data & 8'hfc;
							hca_pkg::EE_REMAP12:   next_r.remap12   = ee_rd_data;
							hca_pkg::EE_REMAP34:   next_r.remap34   = ee_rd_data;
							hca_pkg::EE_REMAP5:    next_r.remap5    = ee_rd_data;
							default: begin
							end
						endcase
					end
				end
			end
			hca_pkg::HCA_NEXT: begin
				// choose next address by scope; hub bytes only on full load
				// mac scope stops after the sixth mac byte;
				// ethernet scope jumps from the flags to max power
				next_r.st = hca_pkg::HCA_REQ;
				if (r.addr == 8'h06 && r.scope == hca_pkg::HCA_SCOPE_MAC) begin
					next_r.st = hca_pkg::HCA_DONE;
				end else if (r.addr == hca_pkg::EE_CFGFLAGS) begin
					if (r.scope == hca_pkg::HCA_SCOPE_FULL) begin
						next_r.addr = hca_pkg::EE_PORTNUM;
					end else begin
						next_r.addr = hca_pkg::EE_MAXPOWER;
					end
				end else if (r.addr == hca_pkg::EE_DNBOOST_L) begin
					next_r.addr = hca_pkg::EE_MAXPOWER;
				end else if (r.addr == hca_pkg::EE_MAXPOWER) begin
					if (r.scope == hca_pkg::HCA_SCOPE_FULL) begin
						next_r.addr = hca_pkg::EE_REMAP12;
					end else begin
						next_r.st = hca_pkg::HCA_DONE;
					end
				end else if (r.addr == hca_pkg::EE_REMAP5) begin
					next_r.st = hca_pkg::HCA_DONE;
				end else begin
					next_r.addr = r.addr + 8'h01;
				end
			end
			hca_pkg::HCA_DONE: begin
				next_r.st = hca_pkg::HCA_IDLE;
			end
			default: begin
				next_r.st = hca_pkg::HCA_IDLE;
			end
		endcase

		// usb reset restarts a mac-only load, even mid-load;
		// six new bytes replace the old mac, so none is cleared
		if (usb_bus_reset) begin
			next_r.st    = hca_pkg::HCA_REQ;
			next_r.scope = hca_pkg::HCA_SCOPE_MAC;
			next_r.addr  = hca_pkg::EE_SIG;
		end

		// soft reset: hub registers to defaults, attach kept, ethernet reload
		// attach survives: only the pin or power-on resets it, back to 1
		// a soft reset mid-load restarts from the signature
		if (wr_go && avs_byteenable[0] && widx == hca_pkg::OFF_STATCMD && wb[hca_pkg::SOFTWARE_RESET_CMD_BIT]) begin
			next_r.portnum   = hca_pkg::RST_PORTNUM;
			next_r.upboost   = hca_pkg::RST_UPBOOST;
			next_r.dnboost_h = hca_pkg::RST_DNBOOST;
			next_r.dnboost_l = hca_pkg::RST_DNBOOST;
			next_r.attach    = r.attach;
			next_r.attach_wr = r.attach_wr;
			next_r.mac       = hca_pkg::DEF_MAC;
			next_r.fs_poll   = hca_pkg::DEF_FS_POLL;
			next_r.hs_poll   = hca_pkg::DEF_HS_POLL;
			next_r.cfgflags  = hca_pkg::DEF_CFGFLAGS;
			next_r.maxpower  = hca_pkg::DEF_MAXPOWER;
			next_r.st        = hca_pkg::HCA_REQ;
			next_r.scope     = hca_pkg::HCA_SCOPE_ETH;
			next_r.addr      = hca_pkg::EE_SIG;
		end

		// power-on or pin reset: everything to defaults, then a full load
		// placed last so it wins over any write in the same cycle
		if (rst || pin_fall) begin
			next_r = '0;
			// power-on presets the synchroniser to the idle level,
			// so no false fall follows the release
			next_r.pin_sync  = rst ? 3'h7 : {r.pin_sync[1:0], external_reset_pin_n};
			// after a pin reset the level stays low until seen high
			next_r.pin_level = rst ? 1'b1 : 1'b0;
			next_r.portnum   = hca_pkg::RST_PORTNUM;
			next_r.upboost   = hca_pkg::RST_UPBOOST;
			next_r.dnboost_h = hca_pkg::RST_DNBOOST;
			next_r.dnboost_l = hca_pkg::RST_DNBOOST;
			next_r.attach    = hca_pkg::RST_STATCMD[hca_pkg::ATTACH_BIT];
			next_r.mac       = hca_pkg::DEF_MAC;
			next_r.fs_poll   = hca_pkg::DEF_FS_POLL;
			next_r.hs_poll   = hca_pkg::DEF_HS_POLL;
			next_r.cfgflags  = hca_pkg::DEF_CFGFLAGS;
			next_r.maxpower  = hca_pkg::DEF_MAXPOWER;
			next_r.st        = hca_pkg::HCA_REQ;
			next_r.scope     = hca_pkg::HCA_SCOPE_FULL;
			next_r.addr      = hca_pkg::EE_SIG;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// port numbering: remap bytes, or contiguous around disabled ports
	// a disabled port shows zero; enabled ports count from one
	// follows a strap change at once, with no reload
	// remap fields are passed on unchecked
	always_comb begin
		dis_set = self_powered ? r.dis_self : r.dis_bus;
		cnt = 3'h0;
		port_logical_num = 15'h0;
		if (r.portnum[hca_pkg::PORTSEL_BIT]) begin
			// nibble per port: 36h ports 1/2, 37h ports 3/4, 38h port 5
			port_logical_num = {r.remap5[2:0], r.remap34[6:4], r.remap34[2:0], r.remap12[6:4], r.remap12[2:0]};
		end else begin
			for (int i = 0; i < 5; i++) begin
				if (!dis_set[i + 1]) begin
					cnt = cnt + 3'h1;
					port_logical_num[3 * i +: 3] = cnt;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers; reset is folded into the next-state logic
	// so every field shares one synchronous reset path
	always_ff @(posedge clock) begin
		r <= next_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	// waitrequest is combinational: the first cycle stalls
	assign avs_readdata    = r.rdata;
	assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
	assign avs_response    = 2'h0;
	assign ee_rd_req       = r.req;
	assign ee_addr         = r.addr;
	// attach held off while a load runs
	// so the host never sees half-loaded settings
	assign usb_attach      = r.attach && (r.st == hca_pkg::HCA_IDLE);
	assign load_busy       = r.st != hca_pkg::HCA_IDLE;
	// drive codes pass straight to the phys
	// 0 normal, then 4, 8 and 12 percent more drive
	assign upstream_drive_level    = r.upboost[1:0];
	assign fifth_port_drive_level  = r.dnboost_h[1:0];
	assign fourth_port_drive_level = r.dnboost_l[7:6];
	assign third_port_drive_level  = r.dnboost_l[5:4];
	assign second_port_drive_level = r.dnboost_l[3:2];
	// all ones until a programmed eeprom supplies one
	assign mac_address     = r.mac;

endmodule // hca_config_autoload

//--- hca_config_autoload_properties.sv
// port-level checks for the configuration autoload block
// sees only the top module's ports; one clock, synchronous active-high reset
`timescale 1ns/1ns
module hca_config_autoload_properties (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        usb_bus_reset,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	input wire logic        ee_rd_req,
	input wire logic [7:0]  ee_addr,
	input wire logic        ee_rd_valid,
	input wire logic [7:0]  ee_rd_data,
	input wire logic        usb_attach,
	input wire logic        load_busy,
	input wire logic [1:0]  upstream_drive_level,
	input wire logic [47:0] mac_address
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// steps of a bus access and of the signature fetch
	sequence acc_start; $rose(avs_read || avs_write); endsequence
	sequence one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
	sequence sig_fetch; ee_rd_req && ee_addr == hca_pkg::EE_SIG; endsequence
	sequence sig_bad; ee_rd_valid && ee_addr == hca_pkg::EE_SIG && ee_rd_data != hca_pkg::SIGNATURE; endsequence
	////////////////////////////////////////////////////////////////
	chk_bus_wait: assert property (acc_start |-> one_wait)
		else $error("bus access not answered after exactly one wait state");
	chk_resp_okay: assert property (avs_response == 2'h0)
		else $error("bus response not okay");
	chk_attach_idle: assert property (usb_attach |-> !load_busy)
		else $error("attach shown while loader busy");
	chk_req_pulse: assert property (ee_rd_req |=> !ee_rd_req)
		else $error("eeprom request longer than one cycle");
	// the address must hold for the two cycles after the request
	chk_addr_hold: assert property (ee_rd_req |=> $stable(ee_addr) [*2])
		else $error("eeprom address moved before the reply");
	chk_por_sig: assert property ($fell(rst) |-> ##[0:4] sig_fetch)
		else $error("no signature fetch after reset");
	chk_usb_sig: assert property ($rose(usb_bus_reset) && !load_busy |-> ##[1:4] sig_fetch)
		else $error("no signature fetch after usb reset");
	chk_bad_stop: assert property (sig_bad |=> !ee_rd_req [*6])
		else $error("eeprom read after bad signature");
	chk_bad_idle: assert property (sig_bad |-> ##[1:4] !load_busy)
		else $error("loader still busy after bad signature");
	chk_reset_dflt: assert property ($fell(rst) |-> upstream_drive_level == 2'h0 && mac_address == hca_pkg::DEF_MAC)
		else $error("defaults missing after reset");
endmodule // hca_config_autoload_properties

bind hca_config_autoload hca_config_autoload_properties hca_config_autoload_properties_inst (
	.clock(clock), .rst(rst), .usb_bus_reset(usb_bus_reset), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .ee_rd_req(ee_rd_req), .ee_addr(ee_addr),
	.ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data), .usb_attach(usb_attach), .load_busy(load_busy),
	.upstream_drive_level(upstream_drive_level), .mac_address(mac_address));

//--- hca_eep.sv
// behavioural configuration eeprom behind the byte read port
// replies lat cycles after a request; the bench sets the contents and clears the log, the model fills the log
`timescale 1ns/1ns
module hca_eep (
	input  wire logic       clock,
	input  wire logic       ee_rd_req,
	input  wire logic [7:0] ee_addr,
	input  wire logic [2:0] lat,      // reply delay in cycles, at least 1
	output logic            ee_rd_valid,
	output logic      [7:0] ee_rd_data
);
	logic [7:0] mem [0:255];          // device contents
	logic [7:0] seen [$];             // addresses asked for, in order
	logic [7:0] addr_q = 8'h00;
	logic       valid_q = 1'b0;
	logic [7:0] data_q = 8'h00;
	int         cnt = 0;
	////////////////////////////////////////////////////////////////
	// data toggles outside a reply so a stale byte never looks right
	always @(posedge clock) begin
		valid_q <= 1'b0;
		data_q <= ~data_q;
		if (ee_rd_req) begin
			addr_q <= ee_addr;
			cnt <= lat;
			seen.push_back(ee_addr);
		end else if (cnt == 1) begin
			valid_q <= 1'b1;
			data_q <= mem[addr_q];
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
	assign ee_rd_valid = valid_q;
	assign ee_rd_data = data_q;
endmodule // hca_eep

//--- hca_config_autoload_tb.sv
// self-checking bench for the configuration autoload block
// drives the avalon slave and resets; the eeprom model answers the loader
`timescale 1ns/1ns
module hca_config_autoload_tb;
	logic        clock, rst, external_reset_pin_n, usb_bus_reset, self_powered, avs_read, avs_write;
	logic        avs_waitrequest, ee_rd_req, ee_rd_valid, usb_attach, load_busy;
	logic [5:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [1:0]  avs_response, upstream_drive_level, second_port_drive_level, third_port_drive_level;
	logic [1:0]  fourth_port_drive_level, fifth_port_drive_level;
	logic [7:0]  ee_addr, ee_rd_data;
	logic [14:0] port_logical_num;
	logic [47:0] mac_address;
	logic [2:0]  lat;
	int          num_errors, n_tests, seed;
	hca_config_autoload hca_config_autoload_inst (.clock, .rst, .external_reset_pin_n, .usb_bus_reset,
		.self_powered, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
		.avs_readdata, .avs_waitrequest, .avs_response, .ee_rd_req, .ee_addr, .ee_rd_valid, .ee_rd_data,
		.usb_attach, .upstream_drive_level, .second_port_drive_level, .third_port_drive_level,
		.fourth_port_drive_level, .fifth_port_drive_level, .port_logical_num, .mac_address, .load_busy);
	hca_eep hca_eep_inst (.clock, .ee_rd_req, .ee_addr, .lat, .ee_rd_valid, .ee_rd_data);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task check(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one avalon access; held until waitrequest is sampled low at a rising edge
	task bus(input logic wr, input logic [3:0] w, input logic [31:0] wd, output logic [31:0] q);
		int i;
		avs_address <= {w, 2'h0};
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= wd;
		i = 0;
		do begin @(posedge clock); i++; end while (avs_waitrequest !== 1'b0 && i < 50);
		if (avs_waitrequest !== 1'b0) begin num_errors++; end_of_test(); end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask
	task rd_chk(input logic [3:0] w, input logic [31:0] exp);
		bus(1'b0, w, 32'h0, rd);
		check(48'(rd), 48'(exp));
	endtask
	// apply a reset kind (0 por, 1 pin, 2 usb, 3 soft, 4 reload) and wait for the load to end
	task trig(input int k);
		int i;
		hca_eep_inst.seen.delete();
		case (k)
			0: begin rst <= 1'b1; repeat (5) @(posedge clock); rst <= 1'b0; end
			1: begin external_reset_pin_n <= 1'b0; repeat (5) @(posedge clock); external_reset_pin_n <= 1'b1; end
			2: begin usb_bus_reset <= 1'b1; @(posedge clock); usb_bus_reset <= 1'b0; end
			3: bus(1'b1, 4'h4, 32'h2, rd);
			default: bus(1'b1, 4'h6, 32'h1, rd);
		endcase
		i = 0;
		do begin @(negedge clock); i++; end while (!(hca_eep_inst.seen.size() > 0 && load_busy === 1'b0) && i < 3000);
		if (i >= 3000) begin num_errors++; end_of_test(); end
		@(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////
	// expected read order: 0 bad signature, 1 mac only, 2 ethernet, 3 full
	task seq_chk(input int sc);
		logic [7:0] e[$];
		e = {8'h00};
		if (sc > 0) for (int a = 1; a <= (sc == 1 ? 6 : 9); a++) e.push_back(8'(a));
		if (sc == 3) for (int a = 8'h28; a <= 8'h2e; a++) e.push_back(8'(a));
		if (sc > 1) e.push_back(8'h33);
		if (sc == 3) for (int a = 8'h36; a <= 8'h38; a++) e.push_back(8'(a));
		check(48'(hca_eep_inst.seen.size()), 48'(e.size()));
		foreach (e[i]) check(48'(hca_eep_inst.seen[i]), 48'(e[i]));
	endtask
	function automatic logic [7:0] m(input logic [7:0] a);
		return hca_eep_inst.mem[a];
	endfunction
	function automatic logic [47:0] ee_mac();
		return {m(8'h01), m(8'h02), m(8'h03), m(8'h04), m(8'h05), m(8'h06)};
	endfunction
	// mode 0 self powered, 1 bus powered, 2 remap; disable bit n is port n
	function automatic logic [14:0] exp_map(input int md);
		logic [14:0] r;
		logic [7:0]  d;
		int          n;
		if (md == 2) return {3'(m(8'h38)), 3'(m(8'h37) >> 4), 3'(m(8'h37)), 3'(m(8'h36) >> 4), 3'(m(8'h36))};
		d = m(md == 0 ? 8'h2a : 8'h2b);
		n = 1;
		r = '0;
		for (int p = 1; p <= 5; p++) begin
			r[3*p-3 +: 3] = d[p] ? 3'h0 : 3'(n);
			n += d[p] ? 0 : 1;
		end
		return r;
	endfunction
	task hub_chk(input int md);
		logic [7:0] u, h, l;
		u = m(8'h2c);
		h = m(8'h2d);
		l = m(8'h2e);
		rd_chk(4'h0, {24'h0, m(8'h28)});
		rd_chk(4'h1, {30'h0, u[1:0]});
		rd_chk(4'h2, {30'h0, h[1:0]});
		rd_chk(4'h3, {24'h0, l[7:2], 2'h0});
		rd_chk(4'h9, {m(8'h33), m(8'h09), m(8'h08), m(8'h07)});
		check(48'({fifth_port_drive_level, fourth_port_drive_level, third_port_drive_level, second_port_drive_level,
			upstream_drive_level}), 48'({h[1:0], l[7:2], u[1:0]}));
		check(48'(port_logical_num), 48'(exp_map(md)));
		check(mac_address, ee_mac());
		check(48'(usb_attach), 48'h1);
		rd_chk(4'h5, 32'h2);
		rd_chk(4'ha, {17'h0, exp_map(md)});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h3103c653;
		num_errors = 0;
		n_tests = 0;
		{rst, external_reset_pin_n, usb_bus_reset, self_powered, avs_read, avs_write} = 6'h34;
		avs_address = 6'h0;
		avs_writedata = 32'h0;
		lat = 3'h1;
		for (int a = 0; a < 256; a++) hca_eep_inst.mem[a] = 8'hff;
		trig(0);
		seq_chk(0);
		rd_chk(4'h5, 32'h0);
		rd_chk(4'h9, 32'h01050401);
		rd_chk(4'h8, 32'h0000ffff);
		rd_chk(4'h7, 32'hffffffff);
		rd_chk(4'h4, 32'h1);
		rd_chk(4'hf, 32'h0);
		for (int md = 0; md < 3; md++) begin
			for (int a = 0; a < 256; a++) hca_eep_inst.mem[a] = 8'($random(seed));
			hca_eep_inst.mem[0] = 8'ha5;
			hca_eep_inst.mem[8'h28] = (md == 2) ? 8'h08 : 8'h00;
			self_powered <= (md == 0);
			lat <= 3'(1 + ($random(seed) & 3));
			trig(0);
			seq_chk(3);
			hub_chk(md);
			bus(1'b1, 4'h1, 32'hff, rd);
			rd_chk(4'h1, {24'h0, m(8'h2c) & 8'h03});
		end
		bus(1'b1, 4'h4, 32'h0, rd);
		rd_chk(4'h4, 32'h0);
		check(48'(usb_attach), 48'h0);
		bus(1'b1, 4'h1, 32'hff, rd);
		rd_chk(4'h1, 32'h3);
		check(48'(upstream_drive_level), 48'h3);
		bus(1'b1, 4'h4, 32'h1, rd);
		rd_chk(4'h4, 32'h0);
		trig(3);
		seq_chk(2);
		rd_chk(4'h4, 32'h0);
		rd_chk(4'h1, 32'h0);
		rd_chk(4'h0, 32'h0);
		for (int k = 4; k >= 2; k -= 2) begin
			for (int a = 1; a < 7; a++) hca_eep_inst.mem[a] = 8'($random(seed));
			trig(k);
			seq_chk(k == 4 ? 2 : 1);
			check(mac_address, ee_mac());
			check(48'(upstream_drive_level), 48'h0);
		end
		trig(1);
		seq_chk(3);
		rd_chk(4'h4, 32'h1);
		end_of_test();
	end
endmodule // hca_config_autoload_tb
